// ===== pkg/fspc_pkg.sv
// Shared constants and carriers of the flash self-programming controller.
// Assumes a 32-bit classic Wishbone host and a flash macro on one clock.
package fspc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_KEY    = 8'h04;
  localparam logic [7:0] OFS_SRC    = 8'h08;
  localparam logic [7:0] OFS_DEST   = 8'h0c;
  localparam logic [7:0] OFS_LAT_LO = 8'h10;
  localparam logic [7:0] OFS_LAT_HI = 8'h14;
  localparam logic [7:0] OFS_STAT   = 8'h18;
  localparam logic [7:0] OFS_MASK   = 8'h1c;
  // Control field positions
  localparam int CTRL_START_BIT  = 15;
  localparam int CTRL_LAYOUT_BIT = 9;
  localparam int OP_W            = 4;
  // Operation codes in the low control nibble
  localparam logic [3:0] OP_PAIR  = 4'h1;
  localparam logic [3:0] OP_ROW   = 4'h2;
  localparam logic [3:0] OP_ERASE = 4'h3;
  // Unlock key bytes
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // Geometry: row 64 instr (192 bytes), page 8 rows (512 instr)
  localparam int ROW_INSTRS    = 64;
  localparam int PAIRS_PER_ROW = ROW_INSTRS / 2;
  localparam int PAGE_ROWS     = 8;
  localparam logic [23:0] PAIR_STEP = 24'h000004;
  localparam logic [23:0] ROW_SPAN  = 24'h000080;
  localparam logic [23:0] PAGE_SPAN = 24'h000400;
  localparam int PART_BIT      = 22;
  // Status bits
  localparam int STAT_W          = 2;
  localparam int STAT_DONE_BIT   = 0;
  localparam int STAT_REJECT_BIT = 1;
  // Reset values
  localparam logic [3:0]  OP_RST   = 4'h0;
  localparam logic [23:0] ADDR_RST = 24'h000000;
  localparam logic [1:0]  STAT_RST = 2'h0;
  // Words per instruction pair in RAM
  localparam logic [2:0] WORDS_COMP   = 3'h3;
  localparam logic [2:0] WORDS_UNCOMP = 3'h4;

  // Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } fspc_wb_req_t;

  // Two adjacent 24-bit instructions
  typedef struct packed {
    logic [23:0] second;
    logic [23:0] first;
  } fspc_pair_t;

  // Command to the flash array macro
  typedef struct packed {
    logic        req;
    logic [3:0]  op;
    logic [23:0] addr;
    fspc_pair_t  data;
  } fspc_flash_cmd_t;
endpackage

// ===== core/fspc_row_fetch.sv
// Fetches one instruction pair from data RAM in either row layout.
// Assumes RAM returns read data one clock after the read strobe.
module fspc_row_fetch (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               go_i,
  input  wire logic               layout_i,
  input  wire logic [15:0]        ram_rdata_i,
  output logic                    ram_rd_o,
  output logic                    pair_valid_o,
  output fspc_pkg::fspc_pair_t    pair_o
);
  import fspc_pkg::*;

  logic [2:0] issue_reg;   // Reads issued so far
  logic [2:0] cap_reg;     // Words captured so far
  logic       rd_reg;      // Read strobe
  logic       rd_d_reg;    // Data valid this cycle
  logic       valid_reg;   // Pair complete pulse
  fspc_pair_t pair_reg;    // Assembled pair
  logic [2:0] words;       // Words per pair

  // Compressed layout packs both high bytes into one word
  assign words = layout_i ? WORDS_COMP : WORDS_UNCOMP;

  // Read strobe: exactly one word per cycle, no gaps
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_reg    <= 1'b0;
      issue_reg <= 3'h0;
    end
    else if (go_i)
    begin
      rd_reg    <= 1'b1;
      issue_reg <= 3'h1;
    end
    else if (rd_reg)
    begin
      // Stop once the last word is on its way
      if (issue_reg == words)
        rd_reg <= 1'b0;
      else
        issue_reg <= issue_reg + 3'h1;
    end
  end

  // Capture returning words into the pair
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_d_reg  <= 1'b0;
      cap_reg   <= 3'h0;
      valid_reg <= 1'b0;
      pair_reg  <= '0;
    end
    else
    begin
      rd_d_reg  <= rd_reg;
      valid_reg <= rd_d_reg && (cap_reg == words - 3'h1);
      if (go_i)
        cap_reg <= 3'h0;
      else if (rd_d_reg)
      begin
        cap_reg <= cap_reg + 3'h1;
        case (cap_reg)
          3'h0: pair_reg.first[15:0] <= ram_rdata_i;
          3'h1:
          begin
            pair_reg.first[23:16] <= ram_rdata_i[7:0];
            // Second MSB rides in the upper byte here
            if (layout_i)
              pair_reg.second[23:16] <= ram_rdata_i[15:8];
          end
          3'h2: pair_reg.second[15:0] <= ram_rdata_i;
          3'h3: pair_reg.second[23:16] <= ram_rdata_i[7:0];
          default: ;
        endcase
      end
    end
  end

  assign ram_rd_o     = rd_reg;
  assign pair_valid_o = valid_reg;
  assign pair_o       = pair_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_fetch_comp;
    go_i && layout_i ##1 ram_rd_o [*3] ##1 !ram_rd_o;
  endsequence

  a_comp_msb_take: assert property (rd_d_reg && cap_reg == 3'h1 && layout_i
    |=> pair_o.second[23:16] == $past(ram_rdata_i[15:8], 1))
    else $error("second MSB not from upper byte");
  a_comp_pair_time: assert property (s_fetch_comp |-> ##1 pair_valid_o)
    else $error("compressed pair not ready on time");
endmodule

// ===== core/fspc_top.sv
// Flash self-programming controller: Wishbone registers, unlock, sequencer.
// Assumes flash macro and data RAM on clk_i; flash_done_i is a one-cycle
// pulse from that macro, so no synchroniser is needed on it.

module fspc_top #(
  parameter int RAM_AW = 16,
  parameter int PAIRS  = fspc_pkg::PAIRS_PER_ROW
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire fspc_pkg::fspc_wb_req_t  wb_req_i,
  output logic                         wb_ack_o,
  output logic [31:0]                  wb_dat_o,
  output fspc_pkg::fspc_flash_cmd_t    flash_cmd_o,
  input  wire logic                    flash_done_i,
  output logic [RAM_AW-1:0]            ram_addr_o,
  output logic                         ram_rd_o,
  input  wire logic [15:0]             ram_rdata_i,
  output logic                         cpu_stall_o,
  output logic                         irq_o
);
  import fspc_pkg::*;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_ISSUE = 3'b010,
    ST_WAIT  = 3'b011,
    ST_DONE  = 3'b100
  } fspc_state_t;

  // Unlock progress
  typedef enum logic [1:0] {
    KEY_LOCKED = 2'b00,
    KEY_HALF   = 2'b01,
    KEY_OPEN   = 2'b10
  } fspc_key_t;

  fspc_state_t     state_reg;    // Sequencer state
  fspc_state_t     state_next;   // Its next value
  fspc_key_t       key_reg;      // Unlock progress
  logic            ack_reg;      // Bus acknowledge
  logic [31:0]     dat_reg;      // Bus read data
  logic            start_reg;    // Start / busy bit
  logic            layout_reg;   // Row data layout select
  logic [OP_W-1:0] op_reg;       // Selected operation
  logic [RAM_AW-1:0] src_reg;    // Row source RAM address
  logic [23:0]     dest_reg;     // Flash destination address
  logic [23:0]     lat_lo_reg;   // First write latch
  logic [23:0]     lat_hi_reg;   // Second write latch
  logic [STAT_W-1:0] stat_reg;   // Sticky events
  logic [STAT_W-1:0] mask_reg;   // Interrupt enables
  logic            irq_reg;      // Interrupt line
  logic            stall_reg;    // Processor stall
  logic            go_reg;       // Fetch one pair
  logic [5:0]      pair_cnt_reg; // Pairs done in this row
  fspc_flash_cmd_t cmd_reg;      // Flash command

  logic            req_live;     // Request present
  logic            wr_fire;      // Write commits this edge
  logic            rd_fire;      // Read completes this edge
  logic [7:0]      ofs;          // Word-aligned offset
  logic [31:0]     wdat;         // Write data
  logic            start_wr;     // Write asking to start
  logic            start_ok;     // Start accepted
  logic            reject;       // Start refused
  logic            op_known;     // Operation code is valid
  logic            row_op;       // Row program selected
  logic            fetch_rd;     // Fetcher read strobe
  logic            pair_valid;   // Fetched pair ready
  fspc_pair_t      pair_data;    // Fetched pair
  logic [31:0]     rd_word;      // Read mux output
  logic [STAT_W-1:0] stat_set;   // Events this cycle
  logic [STAT_W-1:0] stat_clr;   // Bits being read out

  // Byte-lane merge for partial writes
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        res[8*i +: 8] = new_v[8*i +: 8];
    return res;
  endfunction

  // Bus decode; the write lands on the acknowledged edge only
  assign req_live = wb_req_i.cyc & wb_req_i.stb;
  assign wr_fire  = req_live & wb_req_i.we & ack_reg;
  assign rd_fire  = req_live & ~wb_req_i.we & ack_reg;
  assign ofs      = {wb_req_i.adr[7:2], 2'b00};
  assign wdat     = wb_req_i.dat;

  assign op_known = (op_reg == OP_PAIR) | (op_reg == OP_ROW) |
                    (op_reg == OP_ERASE);
  assign row_op   = (op_reg == OP_ROW);

  // A start needs the key opened by the write just before it
  assign start_wr = wr_fire & (ofs == OFS_CTRL) & wb_req_i.sel[1] &
                    wdat[CTRL_START_BIT];
  assign start_ok = start_wr & (key_reg == KEY_OPEN) &
                    (state_reg == ST_IDLE) & op_known;
  assign reject   = start_wr & ~start_ok;

  // Acknowledge one cycle after the strobe, drop it the next
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= req_live & ~ack_reg;
  end

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (ofs)
      OFS_CTRL:
      begin
        rd_word[CTRL_START_BIT]  = start_reg;
        rd_word[CTRL_LAYOUT_BIT] = layout_reg;
        rd_word[OP_W-1:0]        = op_reg;
      end
      OFS_SRC:    rd_word[RAM_AW-1:0] = src_reg;
      OFS_DEST:   rd_word[23:0] = dest_reg;
      OFS_LAT_LO: rd_word[23:0] = lat_lo_reg;
      OFS_LAT_HI: rd_word[23:0] = lat_hi_reg;
      OFS_STAT:   rd_word[STAT_W-1:0] = stat_reg;
      OFS_MASK:   rd_word[STAT_W-1:0] = mask_reg;
      default:    rd_word = 32'h0000_0000; // Key reads zero too
    endcase
  end

  // Read data is sampled before ack so it is stable at the edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_reg <= 32'h0000_0000;
    else if (req_live & ~ack_reg)
      dat_reg <= rd_word;
  end

  // Unlock tracker: any other write in between relocks
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      key_reg <= KEY_LOCKED;
    else if (wr_fire)
    begin
      if (ofs == OFS_KEY && wb_req_i.sel[0] &&
          wdat[7:0] == KEY_FIRST)
        key_reg <= KEY_HALF;
      else if (ofs == OFS_KEY && wb_req_i.sel[0] &&
               wdat[7:0] == KEY_SECOND && key_reg == KEY_HALF)
        key_reg <= KEY_OPEN;
      else
        key_reg <= KEY_LOCKED;
    end
  end

  // Control fields: frozen while an operation runs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      layout_reg <= 1'b0;
      op_reg     <= OP_RST;
    end
    else if (wr_fire && ofs == OFS_CTRL && state_reg == ST_IDLE)
    begin
      if (wb_req_i.sel[0])
        op_reg <= wdat[OP_W-1:0];
      if (wb_req_i.sel[1])
        layout_reg <= wdat[CTRL_LAYOUT_BIT];
    end
  end

  // Start bit: set on an unlocked start, cleared at completion
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      start_reg <= 1'b0;
    else if (start_ok)
      start_reg <= 1'b1;
    else if (state_reg == ST_DONE)
      start_reg <= 1'b0;
  end

  // Write latches for pair programming
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lat_lo_reg <= ADDR_RST;
      lat_hi_reg <= ADDR_RST;
    end
    else if (wr_fire && state_reg == ST_IDLE)
    begin
      if (ofs == OFS_LAT_LO)
        lat_lo_reg <= 24'(lane_merge({8'h00, lat_lo_reg}, wdat,
                                     wb_req_i.sel));
      if (ofs == OFS_LAT_HI)
        lat_hi_reg <= 24'(lane_merge({8'h00, lat_hi_reg}, wdat,
                                     wb_req_i.sel));
    end
  end

  // Source pointer: written by software, walked by the fetcher
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      src_reg <= '0;
    else if (fetch_rd)
      src_reg <= src_reg + RAM_AW'(2);
    else if (wr_fire && ofs == OFS_SRC && state_reg == ST_IDLE)
      src_reg <= RAM_AW'(lane_merge(32'(src_reg), wdat,
                                    wb_req_i.sel));
  end

  // Destination: row base at a row launch, one pair step per row pair programmed
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dest_reg <= ADDR_RST;
    else if (start_ok && row_op)
      dest_reg <= dest_reg & ~(ROW_SPAN - 24'h1);
    else if (state_reg == ST_WAIT && flash_done_i && row_op)
      dest_reg <= dest_reg + PAIR_STEP;
    else if (wr_fire && ofs == OFS_DEST && state_reg == ST_IDLE)
      dest_reg <= 24'(lane_merge({8'h00, dest_reg}, wdat,
                                 wb_req_i.sel));
  end

  // Sequencer next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (start_ok)
          state_next = row_op ? ST_FETCH : ST_ISSUE;
      ST_FETCH:
        if (pair_valid)
          state_next = ST_ISSUE;
      ST_ISSUE:
        state_next = ST_WAIT;
      ST_WAIT:
        if (flash_done_i)
        begin
          // A row ends after its last pair
          if (row_op && pair_cnt_reg != 6'(PAIRS - 1))
            state_next = ST_FETCH;
          else
            state_next = ST_DONE;
        end
      ST_DONE:
        state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // Sequencer state, fetch trigger and pair counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg    <= ST_IDLE;
      go_reg       <= 1'b0;
      pair_cnt_reg <= 6'h00;
    end
    else
    begin
      state_reg <= state_next;
      go_reg    <= (state_next == ST_FETCH) &&
                   (state_reg != ST_FETCH);
      if (state_reg == ST_IDLE)
        pair_cnt_reg <= 6'h00;
      else if (state_reg == ST_WAIT && flash_done_i)
        pair_cnt_reg <= pair_cnt_reg + 6'h01;
    end
  end

  // Flash command: one request pulse per erase or pair write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cmd_reg <= '0;
    else
    begin
      cmd_reg.req <= (state_reg == ST_ISSUE);
      if (state_reg == ST_ISSUE)
      begin
        cmd_reg.op <= op_reg;
        case (op_reg)
          OP_ERASE:
            cmd_reg.addr <= dest_reg & ~(PAGE_SPAN - 24'h1);
          OP_PAIR:
          begin
            cmd_reg.addr <= dest_reg & ~(PAIR_STEP - 24'h1);
            cmd_reg.data <= '{second: lat_hi_reg, first: lat_lo_reg};
          end
          default:
          begin
            // Row: the walked address and the fetched pair
            cmd_reg.addr <= dest_reg;
            cmd_reg.data <= pair_data;
          end
        endcase
      end
    end
  end

  // Stall only when the target is the running partition
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stall_reg <= 1'b0;
    else
      stall_reg <= (state_next != ST_IDLE) &&
                   (state_next != ST_DONE) &&
                   !dest_reg[PART_BIT];
  end

  // Events; a set in the same cycle as its read-clear wins
  assign stat_set[STAT_DONE_BIT]   = (state_reg == ST_DONE);
  assign stat_set[STAT_REJECT_BIT] = reject;
  assign stat_clr = (rd_fire && ofs == OFS_STAT) ?
                    dat_reg[STAT_W-1:0] : '0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stat_reg <= STAT_RST;
      mask_reg <= STAT_RST;
    end
    else
    begin
      stat_reg <= (stat_reg & ~stat_clr) | stat_set;
      if (wr_fire && ofs == OFS_MASK && wb_req_i.sel[0])
        mask_reg <= wdat[STAT_W-1:0];
    end
  end

  // Interrupt level while any enabled event is pending
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(stat_reg & mask_reg);
  end

  // Pair fetcher for row programming
  fspc_row_fetch u_fetch (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .go_i         (go_reg),
    .layout_i     (layout_reg),
    .ram_rdata_i  (ram_rdata_i),
    .ram_rd_o     (fetch_rd),
    .pair_valid_o (pair_valid),
    .pair_o       (pair_data)
  );

  assign wb_ack_o    = ack_reg;
  assign wb_dat_o    = dat_reg;
  assign flash_cmd_o = cmd_reg;
  assign ram_addr_o  = src_reg;
  assign ram_rd_o    = fetch_rd;
  assign cpu_stall_o = stall_reg;
  assign irq_o       = irq_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_unlock_pair;
    key_reg == KEY_OPEN ##0 start_ok;
  endsequence

  a_start_unlocked: assert property ($rose(start_reg) |->
    $past(key_reg, 1) == KEY_OPEN)
    else $error("start without unlock");
  a_start_launch: assert property (s_unlock_pair |=>
    start_reg && state_reg != ST_IDLE)
    else $error("unlocked start not taken");
  a_reject_quiet: assert property (reject && state_reg == ST_IDLE |=>
    !start_reg ##1 stat_reg[STAT_REJECT_BIT])
    else $error("refused start took effect");
  a_start_clears: assert property (state_reg == ST_DONE |=>
    !start_reg && state_reg == ST_IDLE)
    else $error("start bit not cleared at finish");
  a_stall_active: assert property (state_reg == ST_WAIT &&
    !dest_reg[PART_BIT] && $stable(dest_reg) |-> cpu_stall_o)
    else $error("no stall on active write");
  a_irq_done: assert property (state_reg == ST_DONE &&
    mask_reg[STAT_DONE_BIT] && $stable(mask_reg) |-> ##2 irq_o)
    else $error("completion interrupt missing");
  a_pair_align: assert property (cmd_reg.req && cmd_reg.op == OP_PAIR
    |-> cmd_reg.addr[1:0] == 2'b00)
    else $error("pair address misaligned");
  a_erase_align: assert property (cmd_reg.req && cmd_reg.op == OP_ERASE
    |-> cmd_reg.addr[9:0] == 10'h000)
    else $error("erase not page aligned");
  a_row_slot: assert property (cmd_reg.req && cmd_reg.op == OP_ROW
    |-> cmd_reg.addr[6:0] == {pair_cnt_reg[4:0], 2'b00})
    else $error("row pair out of place");
  a_src_step: assert property (fetch_rd |=>
    src_reg == $past(src_reg, 1) + RAM_AW'(2))
    else $error("source pointer did not advance");
endmodule

// ===== bench/fspc_top_bench.sv
// Self-checking bench of the flash self-programming controller.
// Assumes fspc_pkg; the bench acts as bus master, flash macro and RAM.
module fspc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import fspc_pkg::*;
  logic            clk_i = 1'b0;     // System clock
  logic            rst_i = 1'b1;     // Synchronous reset
  fspc_wb_req_t    wb_req_i = '0;    // Bus request
  logic            wb_ack_o;
  logic [31:0]     wb_dat_o;
  fspc_flash_cmd_t flash_cmd_o;
  fspc_flash_cmd_t last_cmd;         // Last command seen by the flash
  logic            flash_done_i = 1'b0;
  logic [15:0]     ram_addr_o;
  logic [15:0]     ram_rdata_i = '0;
  logic            ram_rd_o;
  logic            cpu_stall_o;
  logic            irq_o;
  int              num_errors = 0;
  int              n_checks = 0;
  int              n_req = 0;        // Flash requests seen
  int              dly = 0;          // Flash busy countdown
  int              n_rd = 0;         // RAM read strobes seen

  // Two pairs per row keeps the row runs short
  fspc_top #(.RAM_AW(16), .PAIRS(2)) fspc_top_inst (.clk_i(clk_i),
    .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .flash_cmd_o(flash_cmd_o),
    .flash_done_i(flash_done_i), .ram_addr_o(ram_addr_o),
    .ram_rd_o(ram_rd_o), .ram_rdata_i(ram_rdata_i),
    .cpu_stall_o(cpu_stall_o), .irq_o(irq_o));

  always #5 clk_i = ~clk_i;

  // RAM content depends on address, so swapped words show up
  function automatic logic [15:0] pat(input logic [15:0] a);
    return {a[7:0] ^ 8'hc3, a[7:0]};
  endfunction

  // RAM answers every address one cycle later
  always @(posedge clk_i)
  begin
    ram_rdata_i <= pat(ram_addr_o);
    if (ram_rd_o === 1'b1)
      n_rd++;
  end

  // Flash macro: done pulse four cycles after each request
  always @(posedge clk_i)
  begin
    // One assignment per edge; a new request restarts the countdown
    flash_done_i <= (flash_cmd_o.req !== 1'b1) && (dly == 1);
    if (flash_cmd_o.req === 1'b1)
    begin
      n_req++;
      last_cmd <= flash_cmd_o;
      dly <= 4;
    end
    else if (dly != 0)
      dly <= dly - 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] rd);
    int i;
    @(posedge clk_i);
    wb_req_i <= '{cyc:1'b1, stb:1'b1, we:w, sel:4'hf, adr:a, dat:d};
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1)
        break;
    end
    rd = wb_dat_o;
    chk(i < 20, 1'b1);
    wb_req_i <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, a, d, x);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    wb(1'b0, a, 32'h0, x);
    chk(x, exp);
  endtask

  // Op first, then both keys, then the start write
  task automatic launch(input logic [15:0] ctrl);
    wr(OFS_CTRL, {16'h0, ctrl});
    wr(OFS_KEY, {24'h0, KEY_FIRST});
    wr(OFS_KEY, {24'h0, KEY_SECOND});
    wr(OFS_CTRL, {16'h0, ctrl | 16'h8000});
    repeat (2) @(posedge clk_i);
  endtask

  // Completion shows up as the level interrupt
  task automatic wait_irq;
    int i;
    for (i = 0; i < 300 && irq_o !== 1'b1; i++)
      @(posedge clk_i);
    chk(irq_o, 1'b1);
  endtask

  task automatic t_refuse;
    wr(OFS_MASK, 32'h3);
    wr(OFS_CTRL, {28'h0, OP_PAIR});
    wr(OFS_CTRL, {28'h0, OP_PAIR} | 32'h8000);
    rdc(OFS_CTRL, {28'h0, OP_PAIR});
    chk(n_req, 0);
    rdc(OFS_STAT, 32'h2);
    rdc(8'h20, 32'h0);
    $display("test refuse done");
  endtask

  task automatic t_pair;
    wr(OFS_LAT_LO, 32'h123456);
    wr(OFS_LAT_HI, 32'h89abcd);
    wr(OFS_DEST, 32'h806);
    launch({12'h0, OP_PAIR});
    chk(cpu_stall_o, 1'b1);
    wait_irq;
    chk(last_cmd.addr, 32'h804);
    chk(last_cmd.data.first, 24'h123456);
    chk(last_cmd.data.second, 24'h89abcd);
    chk(cpu_stall_o, 1'b0);
    rdc(OFS_CTRL, {28'h0, OP_PAIR});
    rdc(OFS_STAT, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    $display("test pair done");
  endtask

  // Row of two pairs to the inactive partition
  task automatic t_row(input logic comp);
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    logic [15:0] d;
    int n0;
    int r0;
    a = pat(comp ? 16'h106 : 16'h108);
    b = pat(comp ? 16'h108 : 16'h10a);
    c = pat(comp ? 16'h10a : 16'h10c);
    d = pat(16'h10e);
    n0 = n_req;
    r0 = n_rd;
    wr(OFS_SRC, 32'h100);
    wr(OFS_DEST, 32'h400090);
    launch({6'h0, comp, 5'h0, OP_ROW});
    chk(cpu_stall_o, 1'b0);
    wait_irq;
    chk(n_req - n0, 2);
    chk(n_rd - r0, comp ? 6 : 8);
    chk(last_cmd.addr, 32'h400084);
    chk(last_cmd.data.first, {b[7:0], a});
    chk(last_cmd.data.second, comp ? {b[15:8], c} : {d[7:0], c});
    rdc(OFS_SRC, comp ? 32'h10c : 32'h110);
    rdc(OFS_DEST, 32'h400088);
    rdc(OFS_STAT, 32'h1);
    $display("test row done");
  endtask

  task automatic t_erase;
    wr(OFS_DEST, 32'habc);
    launch({12'h0, OP_ERASE});
    chk(cpu_stall_o, 1'b1);
    wait_irq;
    chk(last_cmd.addr, 32'h800);
    chk(last_cmd.op, OP_ERASE);
    rdc(OFS_STAT, 32'h1);
    $display("test erase done");
  endtask

  task automatic conclude;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    num_errors++;
    conclude;
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(OFS_CTRL, 32'h0);
    t_refuse;
    t_erase;
    t_pair;
    t_row(1'b1);
    t_row(1'b0);
    conclude;
  end
endmodule
